//--- core/sdac_regs.svh
// Purpose: register offsets, field positions, reset values and frame counts
// Assumes: byte-wide register port, 8-bit offsets
// Notes: definitions only
`ifndef SDAC_REGS_SVH
`define SDAC_REGS_SVH

// register offsets
`define SDAC_OFS_GP_SEL 8'h09
`define SDAC_OFS_UPD_CTRL 8'h28
`define SDAC_OFS_BOOST_MUTE 8'h29
`define SDAC_OFS_LEFT_ATTEN 8'h2a
`define SDAC_OFS_RIGHT_ATTEN 8'h2b
`define SDAC_OFS_ROLE_FMT 8'h2c
`define SDAC_OFS_DEEMPH 8'h2d
`define SDAC_OFS_PWR_OVS 8'h2e

// reset values
`define SDAC_RST_GP_SEL 5'h00
`define SDAC_RST_ATTEN 8'hff
`define SDAC_RST_ROLE 4'h8
`define SDAC_RST_OVS 2'h1

// update control field positions
`define SDAC_BIT_SYNC_EN 7
`define SDAC_BIT_RIGHT_UPD 5
`define SDAC_BIT_LEFT_UPD 4
`define SDAC_BIT_ZC_EN 0

// power, zero flag inversion and de-emphasis field positions
`define SDAC_BIT_PD 7
`define SDAC_BIT_ZF_INV 3
`define SDAC_BIT_DEEMPH_EN 3

// attenuation code limits
`define SDAC_ATTEN_MIN_CODE 8'h37
`define SDAC_ATTEN_STEPS_PER_6DB 8'h0c

// frame counts
`define SDAC_ZERO_FRAMES 1024
`define SDAC_ZC_TIMEOUT_FRAMES 512

`endif

//--- core/sdac_pkg.sv
// Purpose: shared types of the stereo dac control block
// Assumes: nothing
// Notes: constants live in sdac_regs.svh
package sdac_pkg;

  // serial framing selected by the format field
  typedef enum logic [1:0] {
    SDAC_FMT_I2S = 2'b00,
    SDAC_FMT_LJ = 2'b01,
    SDAC_FMT_RJ24 = 2'b10,
    SDAC_FMT_RJ16 = 2'b11
  } sdac_format_type;

endpackage

//--- core/sdac_top.sv
// Purpose: digital control path of the first stereo dac pair
// Assumes: bit clock is 64 times the sample rate, 32-bit slots per channel
// Notes: serial capture runs on bit_clk, everything else on clk
`timescale 1ns/1ps
`include "sdac_regs.svh"

module sdac_top
  import sdac_pkg::*;
#(
  parameter int ZERO_FRAMES = `SDAC_ZERO_FRAMES,
  parameter int ZC_TIMEOUT = `SDAC_ZC_TIMEOUT_FRAMES,
  parameter logic [4:0] ZF_PIN_CODE = 5'h01
) (
  // system clock and reset
  input wire logic clk,
  input wire logic reset,
  // link clock
  input wire logic bit_clk,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // serial audio pins
  input wire logic word_clock_in,
  input wire logic serial_data_in,
  output logic word_clock_out,
  output logic word_clock_oe_n,
  output logic bit_clock_out,
  output logic bit_clock_oe_n,
  // processed samples
  output logic signed [23:0] left_out,
  output logic signed [23:0] right_out,
  output logic out_valid,
  // status and control outputs
  output logic zero_flag,
  output logic gp_pin_out,
  output logic deemph_active,
  output logic [1:0] deemph_rate,
  output logic [1:0] oversample_rate,
  output logic [2:0] ratio_code,
  output logic master_mode,
  output logic pair_powered_down
);

  generate
    if (ZERO_FRAMES < 1 || ZERO_FRAMES > 2047) begin : g_chk_zf
      $error("ZERO_FRAMES out of range");
    end
    if (ZC_TIMEOUT < 1 || ZC_TIMEOUT > 1023) begin : g_chk_zc
      $error("ZC_TIMEOUT out of range");
    end
  endgenerate

  // ---------------- link domain ----------------
  logic [1:0] lrst_sync; // reset carried into the link domain
  logic link_rst;
  logic wc_s1, wc_s2, sd_s1, sd_s2; // pin synchronisers
  logic wc_d; // previous word clock level
  logic [31:0] shreg; // last 32 serial bits
  logic [31:0] slot_hi, slot_lo; // completed half frames
  logic frame_tgl; // flips once per frame

  // reset synchroniser for the link side
  always_ff @(posedge bit_clk) begin
    lrst_sync <= {lrst_sync[0], reset};
  end
  assign link_rst = lrst_sync[1];

  // two flops on both pins keep data and word clock aligned
  always_ff @(posedge bit_clk) begin
    wc_s1 <= word_clock_in;
    wc_s2 <= wc_s1;
    sd_s1 <= serial_data_in;
    sd_s2 <= sd_s1;
  end

  // shift in every bit; the register never needs a reset
  always_ff @(posedge bit_clk) begin
    shreg <= {shreg[30:0], sd_s2};
  end

  // capture a half frame on each word clock edge
  always_ff @(posedge bit_clk) begin
    if (link_rst) begin
      wc_d <= 1'b0;
      frame_tgl <= 1'b0;
      slot_hi <= 32'h0000_0000;
      slot_lo <= 32'h0000_0000;
    end else begin
      wc_d <= wc_s2;
      if (wc_s2 != wc_d && wc_d) begin // end of high half, frame complete
        slot_hi <= shreg;
        frame_tgl <= ~frame_tgl;
      end else if (wc_s2 != wc_d) begin // end of low half
        slot_lo <= shreg;
      end
    end
  end

  // ---------------- register file ----------------
  logic [4:0] gp_sel_reg;
  logic sync_en_reg, zc_en_reg;
  logic [1:0] boost_reg;
  logic [1:0] mute_reg; // [0] left, [1] right
  logic [7:0] atten_reg [0:1]; // [0] left, [1] right
  logic [3:0] role_reg;
  logic [1:0] fmt_reg;
  logic dm_en_reg;
  logic [1:0] dm_rate_reg;
  logic pd_reg, zf_inv_reg;
  logic [1:0] ovs_reg;

  // write decode
  wire wr_gp = reg_write && reg_addr == `SDAC_OFS_GP_SEL;
  wire wr_upd = reg_write && reg_addr == `SDAC_OFS_UPD_CTRL;
  wire wr_bm = reg_write && reg_addr == `SDAC_OFS_BOOST_MUTE;
  wire wr_al = reg_write && reg_addr == `SDAC_OFS_LEFT_ATTEN;
  wire wr_ar = reg_write && reg_addr == `SDAC_OFS_RIGHT_ATTEN;
  wire wr_rf = reg_write && reg_addr == `SDAC_OFS_ROLE_FMT;
  wire wr_dm = reg_write && reg_addr == `SDAC_OFS_DEEMPH;
  wire wr_po = reg_write && reg_addr == `SDAC_OFS_PWR_OVS;
  // update strobes act once and read back as zero
  wire [1:0] upd_strobe = {wr_upd & reg_wdata[`SDAC_BIT_RIGHT_UPD],
                           wr_upd & reg_wdata[`SDAC_BIT_LEFT_UPD]};

  // software-written control bits
  always_ff @(posedge clk) begin
    if (reset) begin
      gp_sel_reg <= `SDAC_RST_GP_SEL;
      sync_en_reg <= 1'b1;
      zc_en_reg <= 1'b0;
      boost_reg <= 2'b00;
      mute_reg <= 2'b00;
      atten_reg[0] <= `SDAC_RST_ATTEN;
      atten_reg[1] <= `SDAC_RST_ATTEN;
      role_reg <= `SDAC_RST_ROLE;
      fmt_reg <= SDAC_FMT_I2S;
      dm_en_reg <= 1'b0;
      dm_rate_reg <= 2'b00;
      pd_reg <= 1'b1;
      ovs_reg <= `SDAC_RST_OVS;
      zf_inv_reg <= 1'b0;
    end else begin
      if (wr_gp) gp_sel_reg <= reg_wdata[4:0];
      if (wr_upd) begin
        sync_en_reg <= reg_wdata[`SDAC_BIT_SYNC_EN];
        zc_en_reg <= reg_wdata[`SDAC_BIT_ZC_EN];
      end
      if (wr_bm) begin
        boost_reg <= reg_wdata[3:2];
        mute_reg <= reg_wdata[1:0];
      end
      if (wr_al) atten_reg[0] <= reg_wdata;
      if (wr_ar) atten_reg[1] <= reg_wdata;
      if (wr_rf) begin
        role_reg <= reg_wdata[7:4];
        fmt_reg <= reg_wdata[1:0];
      end
      if (wr_dm) begin
        dm_en_reg <= reg_wdata[`SDAC_BIT_DEEMPH_EN];
        dm_rate_reg <= reg_wdata[1:0];
      end
      if (wr_po) begin
        pd_reg <= reg_wdata[`SDAC_BIT_PD];
        ovs_reg <= reg_wdata[5:4];
        zf_inv_reg <= reg_wdata[`SDAC_BIT_ZF_INV];
      end
    end
  end

  // read mux; unmapped offsets read zero
  wire [7:0] rd_mux =
    (reg_addr == `SDAC_OFS_GP_SEL) ? {3'b000, gp_sel_reg} :
    (reg_addr == `SDAC_OFS_UPD_CTRL) ? {sync_en_reg, 6'b00_0000, zc_en_reg} :
    (reg_addr == `SDAC_OFS_BOOST_MUTE) ? {4'h0, boost_reg, mute_reg} :
    (reg_addr == `SDAC_OFS_LEFT_ATTEN) ? atten_reg[0] :
    (reg_addr == `SDAC_OFS_RIGHT_ATTEN) ? atten_reg[1] :
    (reg_addr == `SDAC_OFS_ROLE_FMT) ? {role_reg, 2'b00, fmt_reg} :
    (reg_addr == `SDAC_OFS_DEEMPH) ? {4'h0, dm_en_reg, 1'b0, dm_rate_reg} :
    (reg_addr == `SDAC_OFS_PWR_OVS) ? {pd_reg, 1'b0, ovs_reg, zf_inv_reg, 3'b000} :
    8'h00;

  // read data register
  always_ff @(posedge clk) begin
    if (reset) reg_rdata <= 8'h00;
    else if (reg_read) reg_rdata <= rd_mux;
  end

  // ---------------- frame crossing ----------------
  logic tgl_s1, tgl_s2, tgl_d; // toggle synchroniser
  wire frame_evt = tgl_s2 ^ tgl_d; // one pulse per received frame

  // event crossing by toggle
  always_ff @(posedge clk) begin
    if (reset) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_d <= 1'b0;
    end else begin
      tgl_s1 <= frame_tgl;
      tgl_s2 <= tgl_s1;
      tgl_d <= tgl_s2;
    end
  end

  // ---------------- active settings ----------------
  logic [3:0] act_role;
  logic [1:0] act_fmt, act_dm_rate, act_ovs;
  logic act_dm_en;
  wire role_ok = role_reg != 4'h0 && role_reg != 4'h7 && role_reg != 4'hf;
  wire apply_cfg = frame_evt | pd_reg;

  // settings take effect only between frames or while powered down
  always_ff @(posedge clk) begin
    if (reset) begin
      act_role <= `SDAC_RST_ROLE;
      act_fmt <= SDAC_FMT_I2S;
      act_dm_en <= 1'b0;
      act_dm_rate <= 2'b00;
      act_ovs <= `SDAC_RST_OVS;
    end else if (apply_cfg) begin
      if (role_ok) act_role <= role_reg;
      act_fmt <= fmt_reg;
      act_dm_en <= dm_en_reg;
      if (dm_rate_reg != 2'b11) act_dm_rate <= dm_rate_reg;
      act_ovs <= ovs_reg;
    end
  end

  // ---------------- master clock generation ----------------
  wire is_master = ~act_role[3];
  wire [3:0] bdiv = (act_role[2:0] == 3'd1) ? 4'd12 : // 768 fs
                    (act_role[2:0] == 3'd2) ? 4'd8 : // 512 fs
                    (act_role[2:0] == 3'd3) ? 4'd6 : // 384 fs
                    (act_role[2:0] == 3'd4) ? 4'd4 : // 256 fs
                    (act_role[2:0] == 3'd5) ? 4'd3 : 4'd2;
  logic [3:0] bcnt; // system clocks within one bit clock
  logic [4:0] bitcnt; // bit clocks within one half frame
  wire bwrap = bcnt == bdiv - 4'd1;

  // divide the system clock down to 64 fs and fs
  always_ff @(posedge clk) begin
    if (reset || !is_master) begin
      bcnt <= 4'd0;
      bitcnt <= 5'd0;
      word_clock_out <= 1'b0;
      bit_clock_out <= 1'b0;
    end else begin
      bcnt <= bwrap ? 4'd0 : bcnt + 4'd1;
      bit_clock_out <= bcnt >= (bdiv >> 1);
      if (bwrap) begin
        bitcnt <= bitcnt + 5'd1;
        if (bitcnt == 5'd31) word_clock_out <= ~word_clock_out;
      end
    end
  end

  // pins are driven only in master mode
  always_ff @(posedge clk) begin
    if (reset) begin
      word_clock_oe_n <= 1'b1;
      bit_clock_oe_n <= 1'b1;
    end else begin
      word_clock_oe_n <= ~is_master;
      bit_clock_oe_n <= ~is_master;
    end
  end

  // ---------------- sample extraction ----------------
  function automatic logic [23:0] extract(input logic [31:0] s, input logic [1:0] f);
    case (f)
      SDAC_FMT_I2S: extract = s[30:7];
      SDAC_FMT_LJ: extract = s[31:8];
      SDAC_FMT_RJ24: extract = s[23:0];
      default: extract = {s[15:0], 8'h00};
    endcase
  endfunction

  // i2s places left in the low half, the justified formats in the high half
  wire lo_is_left = act_fmt == SDAC_FMT_I2S;
  logic signed [23:0] in_smp [0:1]; // captured input samples
  logic in_valid;

  // take the new frame into the processing clock
  always_ff @(posedge clk) begin
    if (reset) begin
      in_smp[0] <= 24'h00_0000;
      in_smp[1] <= 24'h00_0000;
      in_valid <= 1'b0;
    end else begin
      in_valid <= frame_evt;
      if (frame_evt) begin
        in_smp[0] <= extract(lo_is_left ? slot_lo : slot_hi, act_fmt);
        in_smp[1] <= extract(lo_is_left ? slot_hi : slot_lo, act_fmt);
      end
    end
  end

  // gain of one half-decibel step within a 6 dB octave, 1.15 format
  function automatic logic [16:0] mant(input logic [7:0] r);
    case (r)
      8'd0: mant = 17'd32768;
      8'd1: mant = 17'd30929;
      8'd2: mant = 17'd29193;
      8'd3: mant = 17'd27554;
      8'd4: mant = 17'd26008;
      8'd5: mant = 17'd24548;
      8'd6: mant = 17'd23170;
      8'd7: mant = 17'd21870;
      8'd8: mant = 17'd20643;
      8'd9: mant = 17'd19484;
      8'd10: mant = 17'd18390;
      default: mant = 17'd17358;
    endcase
  endfunction

  // ---------------- per channel level path ----------------
  logic signed [23:0] proc [0:1];
  logic [1:0] ch_zero;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [7:0] tgt_code_reg, app_code_reg;
      logic tgt_mute_reg, app_mute_reg;
      logic [9:0] zc_cnt_reg;
      logic sign_reg;
      // with sync update off the written level is the target at once
      wire [7:0] tgt_code = sync_en_reg ? tgt_code_reg : atten_reg[ch];
      wire tgt_mute = sync_en_reg ? tgt_mute_reg : mute_reg[ch];
      wire pending = tgt_code != app_code_reg || tgt_mute != app_mute_reg;
      wire crossed = in_smp[ch][23] != sign_reg;
      wire timed_out = zc_cnt_reg == 10'(ZC_TIMEOUT - 1);
      wire apply_now = !zc_en_reg || (in_valid && (crossed || timed_out));

      // latch the staged level on the strobe; while sync update is off it
      // tracks the written level, so turning sync on later cannot revert it
      always_ff @(posedge clk) begin
        if (reset) begin
          tgt_code_reg <= `SDAC_RST_ATTEN;
          tgt_mute_reg <= 1'b0;
        end else if (upd_strobe[ch] || !sync_en_reg) begin
          tgt_code_reg <= atten_reg[ch];
          tgt_mute_reg <= mute_reg[ch];
        end
      end

      // applied level, waiting for a zero crossing when enabled
      always_ff @(posedge clk) begin
        if (reset) begin
          app_code_reg <= `SDAC_RST_ATTEN;
          app_mute_reg <= 1'b0;
          zc_cnt_reg <= 10'd0;
          sign_reg <= 1'b0;
        end else begin
          if (in_valid) sign_reg <= in_smp[ch][23];
          if (pending && apply_now) begin
            app_code_reg <= tgt_code;
            app_mute_reg <= tgt_mute;
            zc_cnt_reg <= 10'd0;
          end else if (pending && in_valid) begin
            zc_cnt_reg <= zc_cnt_reg + 10'd1;
          end else if (!pending) begin
            zc_cnt_reg <= 10'd0;
          end
        end
      end

      // boost ahead of attenuation, saturating at full scale
      wire signed [26:0] wide = 27'(in_smp[ch]) <<< boost_reg;
      wire sat = wide[26:23] != {4{wide[23]}};
      wire signed [23:0] boosted = !sat ? wide[23:0] :
                                   wide[26] ? 24'h80_0000 : 24'h7f_ffff;
      // code ff is 0 dB, each step down is a further 0.5 dB
      wire [7:0] steps = 8'hff - app_code_reg;
      wire [7:0] oct = steps / `SDAC_ATTEN_STEPS_PER_6DB;
      wire [7:0] rem = steps % `SDAC_ATTEN_STEPS_PER_6DB;
      wire signed [40:0] prod = boosted * $signed(mant(rem));
      wire signed [40:0] scaled = prod >>> (oct + 8'd15);
      // mute bit or a code below the range forces zero
      wire muted = app_mute_reg || app_code_reg < `SDAC_ATTEN_MIN_CODE;

      assign proc[ch] = muted ? 24'h00_0000 : scaled[23:0];
      assign ch_zero[ch] = in_smp[ch] == 24'h00_0000;
    end
  endgenerate

  // ---------------- outputs of the level path ----------------
  always_ff @(posedge clk) begin
    if (reset) begin
      left_out <= 24'h00_0000;
      right_out <= 24'h00_0000;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid & ~pd_reg;
      left_out <= pd_reg ? 24'h00_0000 : proc[0];
      right_out <= pd_reg ? 24'h00_0000 : proc[1];
    end
  end

  // ---------------- zero detection ----------------
  logic [10:0] zcount_reg; // frames of continuous zero input
  wire zero_seen = zcount_reg == 11'(ZERO_FRAMES);

  // count zero frames, saturating at the threshold
  always_ff @(posedge clk) begin
    if (reset) begin
      zcount_reg <= 11'd0;
    end else if (in_valid) begin
      if (ch_zero != 2'b11) zcount_reg <= 11'd0;
      else if (!zero_seen) zcount_reg <= zcount_reg + 11'd1;
    end
  end

  // status and control outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      zero_flag <= 1'b0;
      gp_pin_out <= 1'b0;
      deemph_active <= 1'b0;
      deemph_rate <= 2'b00;
      oversample_rate <= `SDAC_RST_OVS;
      ratio_code <= 3'd0;
      master_mode <= 1'b0;
      pair_powered_down <= 1'b1;
    end else begin
      zero_flag <= zero_seen ^ zf_inv_reg;
      gp_pin_out <= (gp_sel_reg == ZF_PIN_CODE) & (zero_seen ^ zf_inv_reg);
      deemph_active <= act_dm_en & ~pd_reg;
      deemph_rate <= act_dm_rate;
      oversample_rate <= act_ovs;
      ratio_code <= act_role[2:0];
      master_mode <= is_master;
      pair_powered_down <= pd_reg;
    end
  end

endmodule

//--- verification/sdac_props.sv
// Purpose: concurrent checks on the dac control ports
// Assumes: one system clock domain, synchronous active-high reset
// Notes: bound to sdac_top below the module
`timescale 1ns/1ps

module sdac_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // pins and status
  input wire logic word_clock_oe_n,
  input wire logic bit_clock_oe_n,
  input wire logic out_valid,
  input wire logic zero_flag,
  input wire logic deemph_active,
  input wire logic [1:0] deemph_rate,
  input wire logic [1:0] oversample_rate,
  input wire logic [2:0] ratio_code,
  input wire logic master_mode,
  input wire logic pair_powered_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // leaving reset the pair is down, default oversampling, slave role
  property p_reset_vals;
    $fell(reset) |-> pair_powered_down && oversample_rate == 2'b01 && !master_mode;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset state of pair wrong");

  // no samples leave a powered-down pair
  property p_pd_quiet;
    pair_powered_down [*2] |-> !out_valid;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("sample emitted while powered down");

  // master drives both clock pins, slave releases them
  property p_master_oe;
    master_mode [*3] |-> !word_clock_oe_n && !bit_clock_oe_n;
  endproperty
  a_master_oe: assert property (p_master_oe)
    else $error("master not driving clock pins");

  property p_slave_oe;
    !master_mode [*3] |-> word_clock_oe_n && bit_clock_oe_n;
  endproperty
  a_slave_oe: assert property (p_slave_oe)
    else $error("slave driving clock pins");

  // master always runs with one of the six ratios
  property p_master_ratio;
    master_mode |-> ratio_code != 3'h0 && ratio_code != 3'h7;
  endproperty
  a_master_ratio: assert property (p_master_ratio)
    else $error("master with no valid ratio");

  // reserved codes never become active
  property p_rate_legal;
    deemph_rate != 2'b11 && ratio_code != 3'h7;
  endproperty
  a_rate_legal: assert property (p_rate_legal)
    else $error("reserved code became active");

  // filter stays out of the path while powered down
  property p_deemph_pd;
    pair_powered_down [*2] |-> !deemph_active;
  endproperty
  a_deemph_pd: assert property (p_deemph_pd)
    else $error("de-emphasis active while down");

  // update strobes clear themselves and read back as zero
  property p_strobe_reads;
    reg_read && reg_addr == 8'h28 |=> reg_rdata[6:4] == 3'b000;
  endproperty
  a_strobe_reads: assert property (p_strobe_reads)
    else $error("update strobe read back set");

  // one pulse per frame, frames are far apart
  property p_valid_pulse;
    out_valid |=> !out_valid [*8];
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("sample pulse too long");

  c_frame: cover property (out_valid);
  c_master: cover property (master_mode);
  c_zero: cover property (zero_flag);
endmodule

bind sdac_top sdac_checker u_checker (
  .clk, .reset, .reg_addr, .reg_read, .reg_rdata, .word_clock_oe_n, .bit_clock_oe_n,
  .out_valid, .zero_flag, .deemph_active, .deemph_rate, .oversample_rate, .ratio_code,
  .master_mode, .pair_powered_down
);

//--- verification/sdac_source.sv
// Purpose: serial audio source feeding the dac pair in slave role
// Assumes: 64 bit clocks per frame, i2s framing
// Notes: changes pins on falling bit clock, design samples on rising
`timescale 1ns/1ps

module sdac_source (
  // link clock
  input wire logic bit_clk,
  // samples to send
  input wire logic [23:0] left_smp,
  input wire logic [23:0] right_smp,
  // serial pins
  output logic word_clock,
  output logic sdata
);
  logic [5:0] slot_reg = 6'h00; // bit position in frame
  logic [5:0] slot_next; // next bit position
  logic [4:0] nidx; // bit position in half frame
  logic [23:0] cur; // sample of the coming half

  assign slot_next = slot_reg + 6'h01;
  assign nidx = slot_next[4:0];
  assign cur = slot_next[5] ? right_smp : left_smp;

  initial word_clock = 1'b0;
  initial sdata = 1'b0;

  // low half left, high half right, msb one bit after the edge
  always @(negedge bit_clk) begin
    slot_reg <= slot_next;
    word_clock <= slot_next[5];
    // unused bits toggle so a stale value never looks valid
    sdata <= (nidx >= 5'h01 && nidx <= 5'h18) ? cur[5'h18 - nidx] : ~sdata;
  end
endmodule

//--- verification/sdac_bench.sv
// Purpose: self-checking bench of the dac pair control
// Assumes: slave source drives frames, bench makes the 12 ns bit clock
// Notes: small zero and timeout counts shorten the run
`timescale 1ns/1ps

module sdac_bench;
  // clocks and reset
  logic clk, reset, gen_bclk;
  wire bit_clk, word_clock_pin;
  // register port
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_write, reg_read;
  // pins and outputs
  logic src_wclk, src_data, word_clock_out, word_clock_oe_n, bit_clock_out, bit_clock_oe_n;
  logic signed [23:0] left_out, right_out;
  logic out_valid, zero_flag, gp_pin_out, deemph_active, master_mode, pair_powered_down;
  logic [1:0] deemph_rate, oversample_rate, exp_rate;
  logic [2:0] ratio_code;
  logic [3:0] exp_role;
  logic [23:0] left_smp, right_smp;
  logic [7:0] rst_addr [9] = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h28, 8'h29, 8'h09, 8'h00};
  logic [7:0] rst_val [9] = '{8'hff, 8'hff, 8'h80, 8'h00, 8'h90, 8'h80, 8'h00, 8'h00, 8'h00};
  int n_fail, n_tests;

  // open pins resolve to whoever enables them
  assign bit_clk = bit_clock_oe_n ? gen_bclk : bit_clock_out;
  assign word_clock_pin = word_clock_oe_n ? src_wclk : word_clock_out;

  sdac_top #(.ZERO_FRAMES(4), .ZC_TIMEOUT(4)) dut (
    .clk, .reset, .bit_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .word_clock_in(word_clock_pin), .serial_data_in(src_data), .word_clock_out,
    .word_clock_oe_n, .bit_clock_out, .bit_clock_oe_n, .left_out, .right_out, .out_valid,
    .zero_flag, .gp_pin_out, .deemph_active, .deemph_rate, .oversample_rate, .ratio_code,
    .master_mode, .pair_powered_down
  );

  sdac_source u_src (.bit_clk(bit_clk), .left_smp(left_smp), .right_smp(right_smp),
    .word_clock(src_wclk), .sdata(src_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // link clock, phase unrelated to clk
  initial begin
    gen_bclk = 1'b0;
    #3;
    forever #6 gen_bclk = ~gen_bclk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    #1;
    chk({16'h0000, reg_rdata}, {16'h0000, e});
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // wait for n sample pulses, each bounded
  task automatic frames(input int n);
    int k;
    for (int f = 0; f < n; f++) begin
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while (out_valid !== 1'b1 && k < 300);
      if (k >= 300) begin
        n_fail++;
        $display("BAD %0t no sample pulse", $time);
      end
    end
  endtask

  // fresh samples need a full frame after the change
  task automatic expect_pair(input logic [23:0] l, input logic [23:0] r);
    frames(3);
    chk(left_out, l);
    chk(right_out, r);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    {left_smp, right_smp} = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 9; i++) rd(rst_addr[i], rst_val[i]);
    chk(pair_powered_down, 1'b1);
    // every role code, reserved ones keep the last active role
    exp_role = 4'h8;
    for (int c = 0; c < 16; c++) begin
      if (c != 0 && c != 7 && c != 15) exp_role = c[3:0];
      wr(8'h2c, {c[3:0], 4'h0});
      settle();
      chk({master_mode, ratio_code}, {~exp_role[3], exp_role[2:0]});
    end
    wr(8'h2c, 8'h80);
    wr(8'h2e, 8'h80);
    settle();
    chk(oversample_rate, 2'b00);
    wr(8'h2e, 8'hb0);
    settle();
    chk(oversample_rate, 2'b11);
    // every de-emphasis rate, 11 keeps the previous one
    for (int r = 0; r < 4; r++) begin
      if (r != 3) exp_rate = r[1:0];
      wr(8'h2d, {6'h02, r[1:0]});
      settle();
      chk({deemph_active, deemph_rate}, {1'b0, exp_rate});
    end
    wr(8'h2e, 8'h10);
    frames(2);
    chk({pair_powered_down, oversample_rate, deemph_active}, 4'h3);
    wr(8'h2d, 8'h00);
    left_smp <= 24'h01_2345;
    right_smp <= 24'h05_4321;
    expect_pair(24'h01_2345, 24'h05_4321);
    // a level written under sync update waits for its strobe
    wr(8'h2b, 8'h36);
    expect_pair(24'h01_2345, 24'h05_4321);
    rd(8'h2b, 8'h36);
    wr(8'h28, 8'ha0);
    rd(8'h28, 8'h80);
    expect_pair(24'h01_2345, 24'h00_0000);
    wr(8'h2b, 8'hff);
    wr(8'h29, 8'h05);
    wr(8'h28, 8'hb0);
    expect_pair(24'h00_0000, 24'h0a_8642);
    wr(8'h2a, 8'hf3);
    wr(8'h29, 8'h0c);
    wr(8'h28, 8'hb0);
    frames(3);
    chk(right_out, 24'h2a_1908);
    // 18 dB up then -6 dB keeps 0.5012, allow about 0.03 dB
    n_tests++;
    if ($isunknown(left_out) || left_out < 24'sh04_8bf0 || left_out > 24'sh04_93c0) begin
      n_fail++;
      $display("BAD %0t left level %h", $time, left_out);
    end
    // zero-cross wait on steady positive data, so only the timeout applies
    wr(8'h29, 8'h0e);
    wr(8'h28, 8'ha1);
    frames(2);
    chk(right_out, 24'h2a_1908);
    frames(4);
    chk(right_out, 24'h00_0000);
    // -3 dB on the right, allow about 0.05 dB
    wr(8'h29, 8'h0c);
    wr(8'h2b, 8'hf9);
    wr(8'h28, 8'ha0);
    frames(3);
    n_tests++;
    if ($isunknown(right_out) || right_out < 24'sh1d_a000 || right_out > 24'sh1d_f000) begin
      n_fail++;
      $display("BAD %0t right level %h", $time, right_out);
    end
    // direct writes with sync off, then sync on again keeps the level
    wr(8'h28, 8'h00);
    wr(8'h2b, 8'hff);
    wr(8'h28, 8'h80);
    frames(3);
    chk(right_out, 24'h2a_1908);
    left_smp <= 24'h00_0000;
    right_smp <= 24'h00_0000;
    wr(8'h09, 8'h01);
    frames(10);
    chk({zero_flag, gp_pin_out}, 2'b11);
    wr(8'h2e, 8'h18);
    settle();
    chk(zero_flag, 1'b0);
    left_smp <= 24'h00_0001;
    frames(3);
    chk(zero_flag, 1'b1);
    wrap_up();
  end

  // cut a hang short
  initial begin
    repeat (10000) @(posedge clk);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
